// File: rtl/wdt_map.svh
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// register addresses
`define KEY_ADDR    8'hA6
`define CTRL_ADDR   8'hA7

// key bytes
`define KEY_FEED1   8'h1E
`define KEY_FEED2   8'hE1
`define KEY_SW1     8'h5A
`define KEY_SW2     8'hA5

// control/status field positions
`define PS_HI       7
`define PS_LO       5
`define IDLE_BIT    4
`define RESET_OUTPUT_DISABLE_BIT  3
`define SOFTWARE_RESET_FLAG_BIT   2
`define OVF_BIT     1
`define RUN_BIT     0

// reset values
`define PS_RESET    3'h0
`define BIT_RESET   1'b0
`define RDATA_IDLE  8'h00

// counter widths
`define TPS_W       4
`define PRE_W       7
`define CNT_W       14

`endif

// File: rtl/wdt_pkg.sv
package wdt_pkg;
    typedef enum logic [1:0] {KEY_IDLE, KEY_FEED_HALF, KEY_SW_HALF} key_state_t;
    typedef logic [7:0] sfr_byte_t;
endpackage

// File: rtl/wdt_stage_counter.sv
`timescale 1ns/1ps
module wdt_stage_counter
#(
    parameter int W = 7
)
(
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic         clr,
    input  wire logic         inc,
    output logic [W-1:0]      count_r
);
    logic [W-1:0] count_nxt;

    always_comb
    begin
        if (clr)
            count_nxt = '0;
        else if (inc)
            count_nxt = count_r + 1'b1;
        else
            count_nxt = count_r;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            count_r <= '0;
        else
            count_r <= count_nxt;
    end
endmodule

// File: rtl/watchdog_with_software_reset.sv
// Overview of operation
// - period field doubles 16K up to 2048K
// - time-out 2^(period+14) times prescale plus one
// - 14-bit counter behind 7-bit prescaler
// - disabled after reset, halted in power-down
// - 1EH then E1H starts, running bit set
// - running bit read-only, reflects counter state
// - reads allowed between keys, writes break
// - overflow gives reset pulse, sets overflow flag
// - 5AH then A5H software reset, flag only
// - wrong key sequence resets, sets both flags
// - software-reset flag kept, cleared by zero
// - overflow flag kept, cleared by software
`timescale 1ns/1ps
`include "wdt_map.svh"
module watchdog_with_software_reset
    import wdt_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    input  wire logic               other_reset,
    input  wire logic               idle_mode,
    input  wire logic               pd_mode,
    input  wire logic [`TPS_W-1:0]  general_timer_prescale,
    input  wire logic               reset_pin_polarity,
    input  wire logic [7:0]         sfr_addr,
    input  wire logic [7:0]         sfr_wdata,
    input  wire logic               sfr_wr,
    input  wire logic               sfr_rd,
    output logic [7:0]              sfr_rdata_r,
    output logic                    wdt_reset_r,
    output logic                    reset_pin_out_r,
    output logic                    reset_pin_oe_r
);
    // ==========================================================
    // state
    // ==========================================================
    key_state_t          key_r,         key_nxt;
    logic                running_r,     running_nxt;
    logic [2:0]          period_r,      period_nxt;
    logic                idle_dis_r,    idle_dis_nxt;
    logic                reset_output_disable_r,      reset_output_disable_nxt;
    logic                software_reset_flag_flag_r,  software_reset_flag_flag_nxt;
    logic                ovf_flag_r,    ovf_flag_nxt;
    logic [`TPS_W-1:0]   tps_cnt_r,     tps_cnt_nxt;
    logic [7:0]          rdata_nxt;
    logic                wdt_reset_nxt;
    logic                pin_out_nxt;
    logic                pin_oe_nxt;
    logic [`PRE_W-1:0]   pre_cnt;
    logic [`CNT_W-1:0]   wd_cnt;
    logic [`PRE_W-1:0]   pre_mask;
    logic                key_wr;
    logic                other_wr;
    logic                ctrl_wr;
    logic                cnt_en;
    logic                cnt_clr;
    logic                tps_tick;
    logic                pre_tick;
    logic                ovf_evt;
    logic                feed_ok;
    logic                sw_ok;
    logic                bad_seq;
    logic                gen_rst;

    assign key_wr   = sfr_wr && (sfr_addr == `KEY_ADDR);
    assign other_wr = sfr_wr && (sfr_addr != `KEY_ADDR);
    assign ctrl_wr  = sfr_wr && (sfr_addr == `CTRL_ADDR);

    // ==========================================================
    // time base
    // ==========================================================
    assign cnt_en   = running_r && !pd_mode && !(idle_mode && idle_dis_r);
    assign cnt_clr  = !running_r || gen_rst || other_reset || feed_ok;
    assign tps_tick = cnt_en && (tps_cnt_r == general_timer_prescale);
    assign pre_mask = `PRE_W'((8'h01 << period_r) - 8'h01);
    assign pre_tick = tps_tick && ((pre_cnt & pre_mask) == pre_mask);
    assign ovf_evt  = pre_tick && (&wd_cnt);

    always_comb
    begin
        if (cnt_clr || tps_tick)
            tps_cnt_nxt = '0;
        else if (cnt_en)
            tps_cnt_nxt = tps_cnt_r + 1'b1;
        else
            tps_cnt_nxt = tps_cnt_r;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            tps_cnt_r <= '0;
        else
            tps_cnt_r <= tps_cnt_nxt;
    end

    wdt_stage_counter #(.W(`PRE_W)) u_prescaler
    (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clr     (cnt_clr || pre_tick),
        .inc     (tps_tick),
        .count_r (pre_cnt)
    );

    wdt_stage_counter #(.W(`CNT_W)) u_counter
    (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clr     (cnt_clr),
        .inc     (pre_tick),
        .count_r (wd_cnt)
    );

    // ==========================================================
    // key sequence, control and flags
    // ==========================================================
    always_comb
    begin
        key_nxt        = key_r;
        feed_ok        = 1'b0;
        sw_ok          = 1'b0;
        bad_seq        = 1'b0;
        unique case (key_r)
            KEY_IDLE:
            begin
                if (key_wr && sfr_wdata == `KEY_FEED1)
                    key_nxt = KEY_FEED_HALF;
                else if (key_wr && sfr_wdata == `KEY_SW1)
                    key_nxt = KEY_SW_HALF;
                else if (key_wr)
                    bad_seq = 1'b1;
            end
            KEY_FEED_HALF:
            begin
                if (sfr_wr)
                    key_nxt = KEY_IDLE;
                if (key_wr && sfr_wdata == `KEY_FEED2)
                    feed_ok = 1'b1;
                else if (sfr_wr)
                    bad_seq = 1'b1;
            end
            KEY_SW_HALF:
            begin
                if (sfr_wr)
                    key_nxt = KEY_IDLE;
                if (key_wr && sfr_wdata == `KEY_SW2)
                    sw_ok = 1'b1;
                else if (sfr_wr)
                    bad_seq = 1'b1;
            end
        endcase
        gen_rst = bad_seq || sw_ok || ovf_evt;

        // running bit follows the key logic and the reset sources, never a register write
        running_nxt = running_r;
        if (feed_ok)
            running_nxt = 1'b1;
        if (gen_rst || other_reset)
            running_nxt = 1'b0;

        period_nxt   = period_r;
        idle_dis_nxt = idle_dis_r;
        reset_output_disable_nxt   = reset_output_disable_r;
        if (ctrl_wr)
        begin
            period_nxt   = sfr_wdata[`PS_HI:`PS_LO];
            idle_dis_nxt = sfr_wdata[`IDLE_BIT];
            reset_output_disable_nxt   = sfr_wdata[`RESET_OUTPUT_DISABLE_BIT];
        end
        if (gen_rst || other_reset)
        begin
            key_nxt      = KEY_IDLE;
            period_nxt   = `PS_RESET;
            idle_dis_nxt = `BIT_RESET;
            reset_output_disable_nxt   = `BIT_RESET;
        end

        // flags: only a zero write clears, a set in the same cycle wins
        software_reset_flag_flag_nxt = software_reset_flag_flag_r;
        if (ctrl_wr && !sfr_wdata[`SOFTWARE_RESET_FLAG_BIT])
            software_reset_flag_flag_nxt = 1'b0;
        if (sw_ok || bad_seq)
            software_reset_flag_flag_nxt = 1'b1;
        ovf_flag_nxt = ovf_flag_r;
        if (ctrl_wr && !sfr_wdata[`OVF_BIT])
            ovf_flag_nxt = 1'b0;
        if (ovf_evt || bad_seq)
            ovf_flag_nxt = 1'b1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            key_r        <= KEY_IDLE;
            running_r    <= `BIT_RESET;
            period_r     <= `PS_RESET;
            idle_dis_r   <= `BIT_RESET;
            reset_output_disable_r     <= `BIT_RESET;
            software_reset_flag_flag_r <= `BIT_RESET;
            ovf_flag_r   <= `BIT_RESET;
        end
        else
        begin
            key_r        <= key_nxt;
            running_r    <= running_nxt;
            period_r     <= period_nxt;
            idle_dis_r   <= idle_dis_nxt;
            reset_output_disable_r     <= reset_output_disable_nxt;
            software_reset_flag_flag_r <= software_reset_flag_flag_nxt;
            ovf_flag_r   <= ovf_flag_nxt;
        end
    end

    // ==========================================================
    // outputs
    // ==========================================================
    always_comb
    begin
        rdata_nxt     = `RDATA_IDLE;
        if (sfr_rd && sfr_addr == `CTRL_ADDR)
            rdata_nxt = {period_r, idle_dis_r, reset_output_disable_r, software_reset_flag_flag_r, ovf_flag_r, running_r};
        wdt_reset_nxt = gen_rst;
        pin_oe_nxt    = gen_rst && !reset_output_disable_r;
        pin_out_nxt   = reset_pin_polarity;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            sfr_rdata_r     <= `RDATA_IDLE;
            wdt_reset_r     <= `BIT_RESET;
            reset_pin_out_r <= `BIT_RESET;
            reset_pin_oe_r  <= `BIT_RESET;
        end
        else
        begin
            sfr_rdata_r     <= rdata_nxt;
            wdt_reset_r     <= wdt_reset_nxt;
            reset_pin_out_r <= pin_out_nxt;
            reset_pin_oe_r  <= pin_oe_nxt;
        end
    end

    // ==========================================================
    // assertions
    // ==========================================================
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_feed_first;
        key_r == KEY_IDLE && key_wr && sfr_wdata == `KEY_FEED1 && !ovf_evt && !other_reset;
    endsequence
    sequence s_feed_second;
        key_r == KEY_FEED_HALF && key_wr && sfr_wdata == `KEY_FEED2 && !ovf_evt && !other_reset;
    endsequence
    sequence s_sw_first;
        key_r == KEY_IDLE && key_wr && sfr_wdata == `KEY_SW1 && !ovf_evt && !other_reset;
    endsequence
    sequence s_sw_second;
        key_r == KEY_SW_HALF && key_wr && sfr_wdata == `KEY_SW2 && !ovf_evt;
    endsequence

    a_period_terminal: assert property (ovf_evt |-> (&wd_cnt) && (pre_cnt & pre_mask) == pre_mask)
        else $error("overflow before terminal count");
    a_tps_spacing: assert property (tps_tick |-> tps_cnt_r == general_timer_prescale)
        else $error("prescale tick at wrong count");
    a_pd_halt: assert property (pd_mode && !cnt_clr |=> $stable(wd_cnt) && $stable(pre_cnt))
        else $error("counter moved in power-down");
    a_feed_enable: assert property (s_feed_first ##[1:4] s_feed_second |=> running_r && !wdt_reset_r)
        else $error("feed pair did not start watchdog");
    a_run_readonly: assert property (ctrl_wr && !gen_rst && !other_reset && !feed_ok |=> running_r == $past(running_r))
        else $error("control write changed running bit");
    a_break_write: assert property (key_r != KEY_IDLE && other_wr |=> wdt_reset_r && software_reset_flag_flag_r && ovf_flag_r)
        else $error("intervening write not treated as bad");
    a_overflow_rst: assert property (ovf_evt |=> wdt_reset_r && ovf_flag_r && !running_r)
        else $error("overflow without reset and flag");
    a_sw_reset: assert property (s_sw_first ##[1:4] s_sw_second |=>
        wdt_reset_r && software_reset_flag_flag_r && ovf_flag_r == $past(ovf_flag_r))
        else $error("software reset flags wrong");
    a_flag_hold: assert property (software_reset_flag_flag_r && !(ctrl_wr && !sfr_wdata[`SOFTWARE_RESET_FLAG_BIT]) |=> software_reset_flag_flag_r)
        else $error("software-reset flag lost");
    a_ovf_hold: assert property (ovf_flag_r && !(ctrl_wr && !sfr_wdata[`OVF_BIT]) |=> ovf_flag_r)
        else $error("overflow flag lost");
    a_idle_halt: assert property (idle_mode && idle_dis_r && !cnt_clr |=> $stable(wd_cnt))
        else $error("counter moved while idle-disabled");
    a_pin_drive: assert property (gen_rst |=> reset_pin_oe_r == !$past(reset_output_disable_r) && reset_pin_out_r == $past(reset_pin_polarity))
        else $error("reset pin drive wrong");
endmodule

// File: tb/watchdog_with_software_reset_bench.sv
`timescale 1ns/1ps
`include "wdt_map.svh"
module watchdog_with_software_reset_bench;
    logic       sys_clk;
    logic       rst_n;
    logic       other_reset;
    logic       idle_mode;
    logic       pd_mode;
    logic [3:0] general_timer_prescale;
    logic       reset_pin_polarity;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic       sfr_wr;
    logic       sfr_rd;
    logic [7:0] sfr_rdata_r;
    logic       wdt_reset_r;
    logic       reset_pin_out_r;
    logic       reset_pin_oe_r;
    int         miscompares;
    int         num_checks;
    int         pulse_n;
    logic [7:0] rd_val;
    logic       seen;
    logic       pulse_oe;
    logic       pulse_out;

    watchdog_with_software_reset u_watchdog_with_software_reset (
        .sys_clk                (sys_clk),
        .rst_n                  (rst_n),
        .other_reset            (other_reset),
        .idle_mode              (idle_mode),
        .pd_mode                (pd_mode),
        .general_timer_prescale (general_timer_prescale),
        .reset_pin_polarity     (reset_pin_polarity),
        .sfr_addr               (sfr_addr),
        .sfr_wdata              (sfr_wdata),
        .sfr_wr                 (sfr_wr),
        .sfr_rd                 (sfr_rd),
        .sfr_rdata_r            (sfr_rdata_r),
        .wdt_reset_r            (wdt_reset_r),
        .reset_pin_out_r        (reset_pin_out_r),
        .reset_pin_oe_r         (reset_pin_oe_r)
    );

    // ==========================================
    // clock and watchdog
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    initial
    begin
        repeat (95000) @(posedge sys_clk);
        miscompares++;
        close_out();
    end

    // ==========================================
    // tasks
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // strobe stands over exactly one rising edge
    task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
        @(negedge sys_clk);
        sfr_addr  = addr;
        sfr_wdata = data;
        sfr_wr    = 1'b1;
        @(negedge sys_clk);
        sfr_wr    = 1'b0;
    endtask

    // data stands for the cycle after the read edge
    task automatic sfr_read(input logic [7:0] addr, input logic [7:0] exp, input string what);
        @(negedge sys_clk);
        sfr_addr = addr;
        sfr_rd   = 1'b1;
        @(negedge sys_clk);
        sfr_rd   = 1'b0;
        chk(what, exp, sfr_rdata_r);
    endtask

    task automatic wait_pulse(input int limit);
        seen    = 1'b0;
        pulse_n = 0;
        // a pulse launched by the last write already stands on return
        while (!seen && pulse_n <= limit)
        begin
            if (wdt_reset_r === 1'b1)
            begin
                seen      = 1'b1;
                pulse_oe  = reset_pin_oe_r;
                pulse_out = reset_pin_out_r;
            end
            else
            begin
                @(negedge sys_clk);
                pulse_n++;
            end
        end
        chk("reset_pulse", 8'h01, {7'h00, seen});
    endtask

    task automatic no_pulse(input int cycles);
        seen = 1'b0;
        repeat (cycles)
        begin
            @(negedge sys_clk);
            if (wdt_reset_r !== 1'b0)
                seen = 1'b1;
        end
        chk("no_reset_pulse", 8'h00, {7'h00, seen});
    endtask

    task automatic feed();
        sfr_write(`KEY_ADDR, `KEY_FEED1);
        sfr_write(`KEY_ADDR, `KEY_FEED2);
    endtask

    // ==========================================
    // main sequence
    initial
    begin
        rst_n = 1'b0;
        other_reset = 1'b0;
        idle_mode = 1'b0;
        pd_mode = 1'b0;
        general_timer_prescale = 4'h1;
        reset_pin_polarity = 1'b1;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        miscompares = 0;
        num_checks = 0;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        sfr_read(`CTRL_ADDR, 8'h00, "ctrl_after_reset");
        sfr_read(`KEY_ADDR, 8'h00, "key_read");
        sfr_write(`CTRL_ADDR, 8'hFF);
        sfr_read(`CTRL_ADDR, 8'hF8, "ctrl_write_ones");
        sfr_write(`CTRL_ADDR, 8'h00);
        sfr_write(`KEY_ADDR, `KEY_FEED1);
        sfr_read(`CTRL_ADDR, 8'h00, "read_between_keys");
        sfr_write(`KEY_ADDR, `KEY_FEED2);
        sfr_read(`CTRL_ADDR, 8'h01, "running_after_enable");
        wait_pulse(34000);
        chk("timeout_window", 8'h01, {7'h00, pulse_n >= 32765 && pulse_n <= 32771});
        chk("pin_oe_enabled", 8'h01, {7'h00, pulse_oe});
        chk("pin_level", 8'h01, {7'h00, pulse_out});
        general_timer_prescale = 4'h0;
        sfr_read(`CTRL_ADDR, 8'h02, "flags_after_overflow");
        sfr_write(`CTRL_ADDR, 8'h00);
        sfr_read(`CTRL_ADDR, 8'h00, "flags_cleared");
        sfr_write(`KEY_ADDR, `KEY_SW1);
        sfr_write(`KEY_ADDR, `KEY_SW2);
        wait_pulse(8);
        sfr_read(`CTRL_ADDR, 8'h04, "flags_after_sw_reset");
        sfr_write(`CTRL_ADDR, 8'h00);
        sfr_write(`CTRL_ADDR, 8'h08);
        sfr_write(`KEY_ADDR, 8'h33);
        wait_pulse(8);
        chk("pin_oe_disabled", 8'h00, {7'h00, pulse_oe});
        sfr_read(`CTRL_ADDR, 8'h06, "flags_after_bad_key");
        sfr_write(`CTRL_ADDR, 8'h00);
        sfr_write(`KEY_ADDR, `KEY_FEED1);
        sfr_write(`CTRL_ADDR, 8'h00);
        wait_pulse(8);
        sfr_read(`CTRL_ADDR, 8'h06, "flags_after_broken_pair");
        sfr_write(`CTRL_ADDR, 8'h00);
        // halted spans would add up past one period
        feed();
        sfr_write(`CTRL_ADDR, 8'h10);
        no_pulse(10000);
        feed();
        idle_mode = 1'b1;
        no_pulse(9000);
        idle_mode = 1'b0;
        pd_mode = 1'b1;
        no_pulse(9000);
        pd_mode = 1'b0;
        no_pulse(10000);
        sfr_read(`CTRL_ADDR, 8'h11, "ctrl_still_running");
        @(negedge sys_clk);
        other_reset = 1'b1;
        @(negedge sys_clk);
        other_reset = 1'b0;
        sfr_read(`CTRL_ADDR, 8'h00, "ctrl_after_other_reset");
        // idle with counting allowed must still time out
        feed();
        idle_mode = 1'b1;
        wait_pulse(17000);
        chk("idle_count_window", 8'h01, {7'h00, pulse_n >= 16382 && pulse_n <= 16386});
        idle_mode = 1'b0;
        sfr_read(`CTRL_ADDR, 8'h02, "flags_after_idle_overflow");
        close_out();
    end
endmodule
